// ==== hw/irq_flag_pkg.sv ====
package irq_flag_pkg;

    // -------------------------------------------------------------------
    // register indices and byte addresses
    // -------------------------------------------------------------------
    localparam logic [7:0] CPU_FLAGS_IDX = 8'h0a;
    localparam logic [7:0] IRQ_CONTROL_IDX = 8'h0b;
    localparam logic [11:0] CPU_FLAGS_ADDR = {2'h0, CPU_FLAGS_IDX, 2'h0};
    localparam logic [11:0] IRQ_CONTROL_ADDR = {2'h0, IRQ_CONTROL_IDX, 2'h0};

    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int CARRY_BIT = 0;
    localparam int HALF_CARRY_BIT = 1;
    localparam int ZERO_BIT = 2;
    localparam int WRAP_BIT = 3;
    localparam int SLEEP_BIT = 4;
    localparam int EXPIRED_BIT = 5;
    localparam int GLOBAL_EN_BIT = 0;
    localparam int EXT_EN_BIT = 1;
    localparam int TIMER_EN_BIT = 2;
    localparam int EXT_PEND_BIT = 4;
    localparam int TIMER_PEND_BIT = 5;

    // -------------------------------------------------------------------
    // reset values, vectors, stack
    // -------------------------------------------------------------------
    localparam logic [3:0] ARITH_FLAGS_RST = 4'h0;
    localparam logic [9:0] VEC_EXT = 10'h004;
    localparam logic [9:0] VEC_TIMER = 10'h008;
    localparam int STACK_LEVELS = 4;

    // alu operation classes seen by the flag logic
    typedef enum logic [2:0] {
        ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_LOGIC, ALU_RLC, ALU_RRC
    } alu_op_t;

endpackage

// ==== hw/flag_calc_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// operands in, new flag values and update strobes out
interface flag_calc_if;
    import irq_flag_pkg::*;
    logic op_valid;
    alu_op_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] res;
    logic c_in;
    logic c_out;
    logic hc_out;
    logic z_out;
    logic wrap_out;
    logic upd_arith;
    logic upd_c;
    logic upd_z;
    modport calc (input op_valid, op, a, b, res, c_in,
                  output c_out, hc_out, z_out, wrap_out, upd_arith, upd_c, upd_z);
    modport user (output op_valid, op, a, b, res, c_in,
                  input c_out, hc_out, z_out, wrap_out, upd_arith, upd_c, upd_z);
endinterface

`default_nettype wire

// ==== hw/flag_calc.sv ====
`timescale 1ns/1ps
`default_nettype none

module flag_calc
    import irq_flag_pkg::*;
(
    flag_calc_if.calc fc // operands and flag results
);

    // -------------------------------------------------------------------
    // adder with carry, half carry and wrap
    // -------------------------------------------------------------------
    // returns {carry, half carry, wrap, sum}
    function automatic logic [10:0] add_flags(input logic [7:0] x, input logic [7:0] y,
                                              input logic cin);
        logic [4:0] low;
        logic [7:0] upto7;
        logic [8:0] full;
        low = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
        upto7 = {1'b0, x[6:0]} + {1'b0, y[6:0]} + {7'h0, cin};
        full = {1'b0, x} + {1'b0, y} + {8'h0, cin};
        return {full[8], low[4], full[8] ^ upto7[7], full[7:0]};
    endfunction

    logic [10:0] sum;

    // subtraction adds the complement; carry out means no borrow
    always_comb begin
        sum = 11'h0;
        fc.c_out = 1'b0;
        fc.hc_out = 1'b0;
        fc.wrap_out = 1'b0;
        fc.z_out = (fc.res == 8'h00); // RL6
        fc.upd_arith = 1'b0;
        fc.upd_c = 1'b0;
        fc.upd_z = 1'b0;
        unique case (fc.op)
            ALU_ADD, ALU_ADC: begin
                sum = add_flags(fc.a, fc.b, (fc.op == ALU_ADC) & fc.c_in); // RL4
            end
            ALU_SUB, ALU_SBC: begin
                sum = add_flags(fc.a, ~fc.b, (fc.op == ALU_SBC) ? fc.c_in : 1'b1); // RL4
            end
            ALU_LOGIC: begin
                fc.upd_z = fc.op_valid; // RL6
            end
            ALU_RLC: begin
                fc.c_out = fc.a[7]; // RL4
                fc.upd_c = fc.op_valid;
            end
            ALU_RRC: begin
                fc.c_out = fc.a[0]; // RL4
                fc.upd_c = fc.op_valid;
            end
        endcase
        if (fc.op inside {ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC}) begin
            fc.c_out = sum[10]; // RL4
            fc.hc_out = sum[9]; // RL5
            fc.wrap_out = sum[8]; // RL7
            fc.z_out = (sum[7:0] == 8'h00); // RL6
            fc.upd_arith = fc.op_valid;
        end
    end

endmodule // flag_calc

`default_nettype wire

// ==== hw/interrupt_and_flag_unit.sv ====
// Behaviour
// RL1: flag writes leave sleep and expiry flags
// RL2: expiry flag: clear on clear/sleep, set timeout
// RL3: sleep flag: clear on watchdog clear, set sleep
// RL4: carry from add, no-borrow, rotate through carry
// RL5: half carry from low nibble
// RL6: zero flag marks zero result
// RL7: wrap flag when msb carries disagree
// RL8: unused bits read as zero
// RL9: only program counter pushed on entry
// RL10: service clears global enable; requests still latch
// RL11: full stack holds off acknowledge
// RL12: falling pin edge sets external pending
// RL13: external service calls 04h, clears pending, enable
// RL14: timer overflow pending; service calls 08h
// RL15: isr return sets global enable; plain return not
// RL16: requests serviced at next phase-two pulse
// RL17: external beats timer; global enable masks both
// RL18: control bits 0 global, 1 external, 2 timer
// RL19: pending holds until serviced or cleared
// RL20: routine re-enables for nesting
// RL21: both sources wake from sleep
// RL22: arithmetic flags track operations and writes
// RL23: return stack four levels deep
// RL24: hardware set beats software clear
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module interrupt_and_flag_unit
    import irq_flag_pkg::*;
#(
    parameter int STACK_DEPTH = STACK_LEVELS
) (
    input wire logic clock, // 40 MHz clock
    input wire logic rst, // async reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic phase_two_pulse, // request sampling strobe
    input wire logic alu_op_valid, // alu result this cycle
    input wire alu_op_t alu_op, // alu operation class
    input wire logic [7:0] alu_a, // first operand
    input wire logic [7:0] alu_b, // second operand
    input wire logic [7:0] alu_result, // logic or inc/dec result
    input wire logic watchdog_clear_instr, // watchdog clear executed
    input wire logic sleep_instr, // sleep executed
    input wire logic watchdog_timeout, // watchdog expired
    input wire logic timer_overflow, // timer overflow event
    input wire logic call_instr, // subroutine call executed
    input wire logic subroutine_exit_instr, // plain return executed
    input wire logic return_from_isr, // isr return executed
    input wire logic ext_irq_n_pin, // external request pin, active low
    output logic irq_call, // vectored call pulse
    output logic [9:0] irq_vector, // call target
    output logic stack_push, // push program counter pulse
    output logic [2:0] return_stack_index, // stack fill level
    output logic stack_full, // stack holds all levels
    output logic wake_req, // wake from sleep pulse
    output logic carry_flag // carry for chained ops
);

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    logic [3:0] arith_r; // wrap, zero, half carry, carry
    logic sleep_entered_flag_r;
    logic watchdog_expired_flag_r;
    logic global_irq_enable_r;
    logic ext_irq_enable_r;
    logic timer_irq_enable_r;
    logic ext_irq_pending_r;
    logic timer_irq_pending_r;
    logic [2:0] pin_sync_r; // two sync stages plus edge history
    logic [2:0] depth_r;
    logic irq_call_r;
    logic [9:0] irq_vector_r;
    logic push_r;
    logic wake_r;
    logic [31:0] prdata_r;
    logic pslverr_r;

    logic wr_flags;
    logic wr_irq_control;
    logic ext_fall;
    logic ext_ok;
    logic timer_ok;
    logic ack;
    logic ack_ext;
    logic ack_timer;
    logic push;
    logic pop;
    logic [7:0] flags_view;
    logic [7:0] irq_control_view;

    flag_calc_if fc ();

    // -------------------------------------------------------------------
    // apb slave
    // -------------------------------------------------------------------
    function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] reg_addr);
        return addr == reg_addr;
    endfunction

    // writes land in the access phase; only the low lane carries data
    assign wr_flags = psel & penable & pwrite & pstrb[0] & addr_hit(paddr, CPU_FLAGS_ADDR);
    assign wr_irq_control = psel & penable & pwrite & pstrb[0] & addr_hit(paddr, IRQ_CONTROL_ADDR);
    assign pready = psel & penable;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;

    // register views with unused bits tied low
    assign flags_view = {2'b00, watchdog_expired_flag_r, sleep_entered_flag_r, arith_r}; // RL8
    assign irq_control_view = {2'b00, timer_irq_pending_r, ext_irq_pending_r, 1'b0,
                        timer_irq_enable_r, ext_irq_enable_r, global_irq_enable_r}; // RL8

    // read data and error captured in the setup phase
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prdata_r <= 32'h0;
            pslverr_r <= 1'b0;
        end else if (psel & ~penable) begin
            pslverr_r <= ~(addr_hit(paddr, CPU_FLAGS_ADDR) | addr_hit(paddr, IRQ_CONTROL_ADDR));
            if (pwrite) begin
                prdata_r <= 32'h0;
            end else if (addr_hit(paddr, CPU_FLAGS_ADDR)) begin
                prdata_r <= {24'h0, flags_view}; // RL8
            end else if (addr_hit(paddr, IRQ_CONTROL_ADDR)) begin
                prdata_r <= {24'h0, irq_control_view}; // RL8
            end else begin
                prdata_r <= 32'h0;
            end
        end
    end

    // -------------------------------------------------------------------
    // arithmetic flags
    // -------------------------------------------------------------------
    assign fc.op_valid = alu_op_valid;
    assign fc.op = alu_op;
    assign fc.a = alu_a;
    assign fc.b = alu_b;
    assign fc.res = alu_result;
    assign fc.c_in = arith_r[CARRY_BIT];
    assign carry_flag = arith_r[CARRY_BIT];

    flag_calc u_flag_calc (
        .fc(fc)
    );

    // a direct write wins over an alu update in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            arith_r <= ARITH_FLAGS_RST;
        end else if (wr_flags) begin
            arith_r <= pwdata[3:0]; // RL22 RL1
        end else begin
            if (fc.upd_arith) begin
                arith_r <= {fc.wrap_out, fc.z_out, fc.hc_out, fc.c_out}; // RL22
            end else if (fc.upd_c) begin
                arith_r[CARRY_BIT] <= fc.c_out; // RL4
            end else if (fc.upd_z) begin
                arith_r[ZERO_BIT] <= fc.z_out; // RL6
            end
        end
    end

    // -------------------------------------------------------------------
    // sleep and watchdog flags, never touched by writes
    // -------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sleep_entered_flag_r <= 1'b0;
            watchdog_expired_flag_r <= 1'b0;
        end else begin
            if (sleep_instr) begin
                sleep_entered_flag_r <= 1'b1; // RL3
            end else if (watchdog_clear_instr) begin
                sleep_entered_flag_r <= 1'b0; // RL3
            end
            if (watchdog_timeout) begin
                watchdog_expired_flag_r <= 1'b1; // RL2
            end else if (watchdog_clear_instr | sleep_instr) begin
                watchdog_expired_flag_r <= 1'b0; // RL2
            end
        end
    end

    // -------------------------------------------------------------------
    // external pin synchroniser and edge detect
    // -------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_sync_r <= 3'h7;
        end else begin
            pin_sync_r <= {pin_sync_r[1:0], ext_irq_n_pin};
        end
    end

    assign ext_fall = pin_sync_r[2] & ~pin_sync_r[1]; // RL12

    // -------------------------------------------------------------------
    // acknowledge decision at the phase-two pulse
    // -------------------------------------------------------------------
    assign ext_ok = ext_irq_enable_r & ext_irq_pending_r;
    assign timer_ok = timer_irq_enable_r & timer_irq_pending_r;
    assign ack = phase_two_pulse & global_irq_enable_r & (ext_ok | timer_ok)
               & ~stack_full; // RL16 RL11 RL17
    assign ack_ext = ack & ext_ok; // RL17
    assign ack_timer = ack & ~ext_ok; // RL17

    // -------------------------------------------------------------------
    // interrupt control register
    // -------------------------------------------------------------------
    // global enable: service clears, write loads, isr return sets
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            global_irq_enable_r <= 1'b0;
        end else if (ack) begin
            global_irq_enable_r <= 1'b0; // RL10 RL13 RL14
        end else if (wr_irq_control) begin
            global_irq_enable_r <= pwdata[GLOBAL_EN_BIT]; // RL18
        end else if (return_from_isr) begin
            global_irq_enable_r <= 1'b1; // RL15
        end
    end

    // source enables are software owned
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ext_irq_enable_r <= 1'b0;
            timer_irq_enable_r <= 1'b0;
        end else if (wr_irq_control) begin
            ext_irq_enable_r <= pwdata[EXT_EN_BIT]; // RL18
            timer_irq_enable_r <= pwdata[TIMER_EN_BIT]; // RL18
        end
    end

    // pending flags: hardware set beats write and service clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ext_irq_pending_r <= 1'b0;
            timer_irq_pending_r <= 1'b0;
        end else begin
            if (ext_fall) begin
                ext_irq_pending_r <= 1'b1; // RL12 RL24 RL10
            end else if (wr_irq_control) begin
                ext_irq_pending_r <= pwdata[EXT_PEND_BIT]; // RL19
            end else if (ack_ext) begin
                ext_irq_pending_r <= 1'b0; // RL13
            end
            if (timer_overflow) begin
                timer_irq_pending_r <= 1'b1; // RL14 RL24 RL10
            end else if (wr_irq_control) begin
                timer_irq_pending_r <= pwdata[TIMER_PEND_BIT]; // RL19
            end else if (ack_timer) begin
                timer_irq_pending_r <= 1'b0; // RL14
            end
        end
    end

    // -------------------------------------------------------------------
    // vectored call and program counter push
    // -------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_call_r <= 1'b0;
            irq_vector_r <= 10'h000;
            push_r <= 1'b0;
        end else begin
            irq_call_r <= ack;
            push_r <= push; // RL9
            if (ack) begin
                irq_vector_r <= ack_ext ? VEC_EXT : VEC_TIMER; // RL13 RL14 RL17
            end
        end
    end

    assign irq_call = irq_call_r;
    assign irq_vector = irq_vector_r;
    assign stack_push = push_r;

    // -------------------------------------------------------------------
    // return stack fill level
    // -------------------------------------------------------------------
    assign push = ack | call_instr; // RL9
    assign pop = subroutine_exit_instr | return_from_isr;
    assign stack_full = (depth_r == 3'(STACK_DEPTH)); // RL23

    // an overflowing call keeps the level at the top
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            depth_r <= 3'h0;
        end else if (push & ~pop & ~stack_full) begin
            depth_r <= depth_r + 3'h1; // RL23
        end else if (pop & ~push & (depth_r != 3'h0)) begin
            depth_r <= depth_r - 3'h1; // RL11
        end
    end

    assign return_stack_index = depth_r;

    // -------------------------------------------------------------------
    // wake from sleep on a fresh request
    // -------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= sleep_entered_flag_r & ((ext_fall & ~ext_irq_pending_r)
                    | (timer_overflow & ~timer_irq_pending_r)); // RL21
        end
    end

    assign wake_req = wake_r;

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    flags_write_a: assert property (wr_flags && !sleep_instr && !watchdog_clear_instr // RL1
        && !watchdog_timeout |=> $stable(flags_view[5:4]) && flags_view[3:0] == $past(pwdata[3:0]))
        else $error("flag write disturbed sleep or expiry flag");
    expiry_set_a: assert property (watchdog_timeout |=> watchdog_expired_flag_r) // RL2
        else $error("timeout did not set expiry flag");
    sleep_set_a: assert property (sleep_instr && !watchdog_timeout // RL3
        |=> sleep_entered_flag_r && !watchdog_expired_flag_r)
        else $error("sleep did not set sleep flag and clear expiry");
    unused_read_a: assert property (pready && !pslverr |-> prdata[31:6] == 26'h0 // RL8
        && (!addr_hit(paddr, IRQ_CONTROL_ADDR) || !prdata[3]))
        else $error("unused bits read non-zero");
    service_mask_a: assert property (irq_call |-> !global_irq_enable_r && stack_push) // RL10
        else $error("service left global enable set");
    full_block_a: assert property (phase_two_pulse && stack_full |=> !irq_call) // RL11
        else $error("call issued on full stack");
    ext_edge_a: assert property ($fell(pin_sync_r[1]) |=> ext_irq_pending_r) // RL12
        else $error("falling edge lost");
    priority_ext_a: assert property (phase_two_pulse && global_irq_enable_r && ext_ok // RL17
        && timer_ok && !stack_full |=> irq_call && irq_vector == VEC_EXT)
        else $error("external request lost priority");
    timer_vec_a: assert property (phase_two_pulse && global_irq_enable_r && !ext_ok // RL14
        && timer_ok && !stack_full |=> irq_call && irq_vector == VEC_TIMER)
        else $error("timer call wrong");
    isr_return_a: assert property (return_from_isr && !ack && !wr_irq_control // RL15
        |=> global_irq_enable_r)
        else $error("isr return did not re-enable");
    pend_hold_a: assert property (ext_irq_pending_r && !wr_irq_control && !ack_ext // RL19
        |=> ext_irq_pending_r)
        else $error("pending flag dropped");
    masked_quiet_a: assert property (!global_irq_enable_r [*2] |-> !irq_call) // RL17
        else $error("call while globally masked");

    ext_service_c: cover property (irq_call && irq_vector == VEC_EXT);
    timer_service_c: cover property (irq_call && irq_vector == VEC_TIMER);
    full_hold_c: cover property (phase_two_pulse && stack_full && timer_ok && global_irq_enable_r);
    wake_c: cover property (wake_req);

endmodule // interrupt_and_flag_unit

`default_nettype wire

// ==== sim/core_side_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// core-side stand-in: sampling strobe and external request pin
module core_side_model (
    input wire logic clock, // bench clock
    input wire logic rst, // async reset
    input wire logic pin_low, // pull the pin low while set
    output logic phase_two_pulse, // one cycle in four
    output logic ext_irq_n_pin // pin, pulled up when released
);
    logic [1:0] ph_cnt_r;

    // free-running strobe divider
    always_ff @(posedge clock or posedge rst) begin
        if (rst) ph_cnt_r <= 2'h0;
        else ph_cnt_r <= ph_cnt_r + 2'h1;
    end
    assign phase_two_pulse = (ph_cnt_r == 2'h3);
    assign ext_irq_n_pin = ~pin_low;
endmodule // core_side_model

`default_nettype wire

// ==== sim/tb_interrupt_and_flag_unit.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_interrupt_and_flag_unit
    import irq_flag_pkg::*;
;
    logic clock = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic alu_op_valid = 1'h0, pin_low = 1'h0, pslverr, pready, irq_call, p2, ext_n, err_r;
    logic spush, full, cf, wake;
    logic [2:0] lvl;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [7:0] a_v = 8'h0, b_v = 8'h0, res_v = 8'h0;
    logic [6:0] ev = 7'h0; // sleep,timeout,wdclr,tovf,call,ret,return_from_isr
    logic [9:0] irq_vector;
    alu_op_t alu_op = ALU_ADD;
    int n_fail = 0, check_count = 0, n_calls = 0, n_wakes = 0;

    // ------------------------------------------------------------
    // clock, partner, design
    // ------------------------------------------------------------
    always #12.5 clock = ~clock;
    always @(posedge clock) if (irq_call === 1'h1) n_calls++; // counts services
    always @(posedge clock) if (wake === 1'h1) n_wakes++; // counts wake pulses
    core_side_model core (.clock(clock), .rst(rst), .pin_low(pin_low),
        .phase_two_pulse(p2), .ext_irq_n_pin(ext_n));
    interrupt_and_flag_unit dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .phase_two_pulse(p2), .alu_op_valid(alu_op_valid),
        .alu_op(alu_op), .alu_a(a_v), .alu_b(b_v), .alu_result(res_v),
        .watchdog_clear_instr(ev[2]), .sleep_instr(ev[0]), .watchdog_timeout(ev[1]),
        .timer_overflow(ev[3]), .call_instr(ev[4]), .subroutine_exit_instr(ev[5]),
        .return_from_isr(ev[6]), .ext_irq_n_pin(ext_n), .irq_call(irq_call),
        .irq_vector(irq_vector), .stack_push(spush), .return_stack_index(lvl),
        .stack_full(full), .wake_req(wake), .carry_flag(cf));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // apb transfer, waits for pready; the watchdog bounds a hang
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1'h1;
        do @(posedge clock); while (pready !== 1'h1);
        r = prdata;
        err_r = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'h0, a, 8'h0);
        chk(r, {24'h0, e});
    endtask

    task automatic pulse(input logic [6:0] m);
        ev <= m;
        @(posedge clock);
        ev <= 7'h0;
        @(posedge clock);
    endtask

    // waits for a vectored call and checks its target
    task automatic wait_call(input logic [9:0] v);
        int n;
        n = 0;
        while (irq_call !== 1'h1 && n < 40) begin
            @(posedge clock);
            n++;
        end
        chk({20'h0, irq_call, spush, irq_vector}, {20'h0, 2'h3, v});
        @(posedge clock);
    endtask

    task automatic alu(input alu_op_t o, input logic [7:0] a, input logic [7:0] b, input logic [7:0] e);
        alu_op <= o;
        a_v <= a;
        b_v <= b;
        res_v <= a - b;
        alu_op_valid <= 1'h1;
        @(posedge clock);
        alu_op_valid <= 1'h0;
        @(posedge clock);
        rd(CPU_FLAGS_ADDR, e);
        chk({31'h0, cf}, {31'h0, e[0]});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        apb(1'h1, CPU_FLAGS_ADDR, 8'hff);
        rd(CPU_FLAGS_ADDR, 8'h0f);
        apb(1'h1, IRQ_CONTROL_ADDR, 8'hce);
        rd(IRQ_CONTROL_ADDR, 8'h06);
        apb(1'h1, IRQ_CONTROL_ADDR, 8'h00);
        apb(1'h0, 12'h030, 8'h0);
        chk({31'h0, err_r}, 32'h1);
        $display("test regs done");
    endtask

    task automatic t_status();
        pulse(7'h01);
        pulse(7'h02);
        apb(1'h1, CPU_FLAGS_ADDR, 8'h00);
        rd(CPU_FLAGS_ADDR, 8'h30);
        pulse(7'h01);
        rd(CPU_FLAGS_ADDR, 8'h10);
        pulse(7'h04);
        rd(CPU_FLAGS_ADDR, 8'h00);
        alu(ALU_ADD, 8'h7f, 8'h01, 8'h0a);
        alu(ALU_SUB, 8'h10, 8'h10, 8'h07);
        alu(ALU_RLC, 8'h01, 8'h00, 8'h06);
        alu(ALU_RRC, 8'h01, 8'h00, 8'h07);
        alu(ALU_LOGIC, 8'h05, 8'h04, 8'h03);
        alu(ALU_ADC, 8'h0e, 8'h01, 8'h02);
        alu(ALU_SBC, 8'h05, 8'h05, 8'h00);
        $display("test status done");
    endtask

    task automatic t_timer();
        apb(1'h1, IRQ_CONTROL_ADDR, 8'h05);
        pulse(7'h08);
        wait_call(VEC_TIMER);
        pulse(7'h08);
        rd(IRQ_CONTROL_ADDR, 8'h24);
        apb(1'h1, IRQ_CONTROL_ADDR, 8'h04);
        pulse(7'h40);
        rd(IRQ_CONTROL_ADDR, 8'h05);
        $display("test timer done");
    endtask

    task automatic t_prio();
        int c;
        apb(1'h1, IRQ_CONTROL_ADDR, 8'h36);
        c = n_calls;
        repeat (12) @(posedge clock);
        chk(n_calls, c);
        apb(1'h1, IRQ_CONTROL_ADDR, 8'h37);
        wait_call(VEC_EXT);
        rd(IRQ_CONTROL_ADDR, 8'h26);
        apb(1'h1, IRQ_CONTROL_ADDR, 8'h27);
        wait_call(VEC_TIMER);
        pulse(7'h40);
        $display("test priority done");
    endtask

    task automatic t_stack();
        int c;
        repeat (4) pulse(7'h10);
        chk({28'h0, full, lvl}, 32'hc);
        apb(1'h1, IRQ_CONTROL_ADDR, 8'h05);
        pulse(7'h08);
        c = n_calls;
        repeat (12) @(posedge clock);
        chk(n_calls, c);
        pulse(7'h20);
        wait_call(VEC_TIMER);
        pulse(7'h01);
        pin_low <= 1'h1;
        pulse(7'h08);
        repeat (6) @(posedge clock);
        rd(IRQ_CONTROL_ADDR, 8'h34);
        chk(n_wakes, 2);
        chk({28'h0, full, lvl}, 32'hc);
        $display("test stack done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        #(25 * 6000);
        n_fail++;
        final_report();
    end

    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'h0;
        @(posedge clock);
        t_regs();
        t_status();
        t_timer();
        t_prio();
        t_stack();
        final_report();
    end
endmodule // tb_interrupt_and_flag_unit

`default_nettype wire
